// File: pfh_host.sv
// Host controller that drives a parallel NOR flash over its pins
// Notes on behaviour
// - Read: select and gate low, strobe high.
// - Command write: strobe, select low, gate high.
// - Normal program: two unlocks, setup, data.
// - Bypass mode program needs only two cycles.
// - Host flags operations cut by reset; software reissues them.
// - Host waits release-to-read before reading.
// - In-system protect: high clear, A6/A1/A0=0,1,0; the host forces these pins in word mode only, byte mode drives A0=1.
// - Programmer protect: high A9 and gate.
// - Write only with select, strobe low, gate high.
//
// Decided for this implementation: the register offsets and the plain strobed port.
module pfh_host
   import pfh_pkg::*;
#(
   parameter int READ_CYCLES = READ_CYC,
   parameter int WRITE_CYCLES = WRITE_CYC,
   parameter int CLEAR_CYCLES = CLEAR_CYC,
   parameter int RELEASE_CYCLES = RELEASE_CYC
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   output logic [17:0] FL_ADDR_O,
   output logic FL_CHIP_SEL_N_O,
   output logic FL_OUT_GATE_N_O,
   output logic FL_WR_STROBE_N_O,
   output logic FL_CLEAR_N_O,
   output logic FL_WORD_MODE_O,
   output logic FL_CLEAR_HV_O,
   output logic FL_A9_HV_O,
   input wire logic [15:0] FL_DQ_I,
   output logic [15:0] FL_DQ_O,
   output logic FL_DQ_OE_O,
   input wire logic FL_OP_DONE_FLAG_I
);
   initial begin
      if (READ_CYCLES < 1 || WRITE_CYCLES < 1 || CLEAR_CYCLES < 1 || RELEASE_CYCLES < 1 ||
          READ_CYCLES > 255 || WRITE_CYCLES > 255 || CLEAR_CYCLES > 255 || RELEASE_CYCLES > 255)
         $error("pfh_host: cycle counts must lie in 1..255");
   end

   pfh_state_t state_reg, state_next;
   pfh_pins_t pins_reg, pins_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [2:0] op_reg, op_next;
   logic [1:0] step_reg, step_next;
   logic [1:0] last_step_reg, last_step_next;
   logic [18:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg, rdata_next;
   logic [15:0] dq_out_reg, dq_out_next;
   logic dq_oe_reg, dq_oe_next;
   logic word_reg, bypass_reg, hv_clr_reg, hv_a9_reg;
   logic aborted_reg, aborted_next;
   logic [31:0] rdata_bus_reg;
   logic [1:0] ready_sync_reg;
   logic [15:0] dq_meta_reg, dq_sync_reg;

   wire logic busy = (state_reg != ST_IDLE);
   wire logic wr_ctrl = WR_I && (ADDR_I == REG_CTRL);
   wire logic go = wr_ctrl && WDATA_I[CTRL_GO] && !busy;
   wire logic [2:0] go_op = WDATA_I[CTRL_OP_LSB +: 3];
   wire logic [31:0] status_word = {27'h0, aborted_reg, hv_a9_reg, hv_clr_reg, ready_sync_reg[1], busy};
   wire logic [31:0] ctrl_word = {24'h0, hv_a9_reg, hv_clr_reg, bypass_reg, word_reg, op_reg, 1'b0};
   wire logic [31:0] rd_mux = (ADDR_I == REG_CTRL) ? ctrl_word :
                              (ADDR_I == REG_ADDR) ? {13'h0, addr_reg} :
                              (ADDR_I == REG_WDATA) ? {16'h0, wdata_reg} :
                              (ADDR_I == REG_RDATA) ? {16'h0, rdata_reg} :
                              (ADDR_I == REG_STATUS) ? status_word : 32'h0;

   // Byte mode puts address bit zero on the top data line
   function automatic logic [15:0] place_data(input logic word, input logic [18:0] a, input logic [15:0] d);
      return word ? d : {a[0], 7'h0, d[7:0]};
   endfunction

   // Command cycle n of a program sequence; bypass skips both unlocks
   function automatic logic [34:0] prog_cycle(input logic [1:0] n, input logic [18:0] a, input logic [15:0] d);
      case (n)
         2'd0: return {1'b0, UNLOCK_ADDR1, UNLOCK_DATA1};
         2'd1: return {1'b0, UNLOCK_ADDR2, UNLOCK_DATA2};
         2'd2: return {1'b0, UNLOCK_ADDR1, PROG_SETUP_DATA};
         default: return {a, d};
      endcase
   endfunction

   wire logic [34:0] cyc_sel = prog_cycle(step_reg, addr_reg, wdata_reg);
   wire logic [18:0] cyc_addr = (op_reg == OP_PROGRAM) ? cyc_sel[34:16] : addr_reg;
   wire logic [15:0] cyc_data = (op_reg == OP_PROGRAM) ? cyc_sel[15:0] : wdata_reg;
   wire logic [17:0] pin_addr = word_reg ? cyc_addr[17:0] : cyc_addr[18:1];
   // Settings land with go, so the first read cycle takes the width from the write itself
   wire logic [17:0] go_addr = WDATA_I[CTRL_WORD] ? addr_reg[17:0] : addr_reg[18:1];
   wire logic [18:0] prot_addr = (addr_reg & ~PROT_ADDR_MASK) | PROT_ADDR_VAL;

   always_comb begin
      state_next = state_reg;
      pins_next = pins_reg;
      cnt_next = cnt_reg;
      op_next = op_reg;
      step_next = step_reg;
      last_step_next = last_step_reg;
      rdata_next = rdata_reg;
      dq_out_next = dq_out_reg;
      dq_oe_next = dq_oe_reg;
      aborted_next = aborted_reg;
      pins_next.word_mode = word_reg;
      pins_next.clear_hv = hv_clr_reg;
      pins_next.a9_hv = hv_a9_reg;
      case (state_reg)
         ST_IDLE: begin
            // Idle leaves select high so the device floats its outputs
            pins_next.chip_sel_n = 1'b1;
            pins_next.out_gate_n = hv_a9_reg ? 1'b0 : 1'b1;
            pins_next.wr_strobe_n = 1'b1;
            dq_oe_next = 1'b0;
            if (go) begin
               op_next = go_op;
               pins_next.word_mode = WDATA_I[CTRL_WORD];
               cnt_next = '0;
               aborted_next = 1'b0;
               case (go_op)
                  OP_READ: begin
                     state_next = ST_READ;
                     pins_next.addr = go_addr;
                     pins_next.chip_sel_n = 1'b0;
                     pins_next.out_gate_n = 1'b0;
                  end
                  OP_RESET: begin
                     state_next = ST_CLEAR;
                     pins_next.clear_n = 1'b0;
                  end
                  OP_PROGRAM: begin
                     state_next = ST_WSETUP;
                     step_next = WDATA_I[CTRL_BYPASS] ? 2'd2 : 2'd0;
                     last_step_next = 2'd3;
                  end
                  default: begin
                     state_next = ST_WSETUP;
                     step_next = 2'd3;
                     last_step_next = 2'd3;
                  end
               endcase
            end
         end
         ST_READ: begin
            // Address held steady for the full access, so autosleep is harmless
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(READ_CYCLES)) begin
               rdata_next = dq_sync_reg;
               pins_next.chip_sel_n = 1'b1;
               pins_next.out_gate_n = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_WSETUP: begin
            pins_next.addr = pin_addr;
            if (op_reg == OP_PROTECT)
               pins_next.addr = word_reg ? prot_addr[17:0] : prot_addr[18:1];
            pins_next.out_gate_n = 1'b1;
            pins_next.chip_sel_n = 1'b0;
            dq_out_next = place_data(word_reg, (op_reg == OP_PROTECT) ? prot_addr : cyc_addr, cyc_data);
            dq_oe_next = 1'b1;
            cnt_next = '0;
            state_next = ST_WPULSE;
         end
         ST_WPULSE: begin
            // Strobe falls after select so the device latches address here
            pins_next.wr_strobe_n = 1'b0;
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(WRITE_CYCLES)) begin
               pins_next.wr_strobe_n = 1'b1;
               state_next = ST_WHOLD;
            end
         end
         ST_WHOLD: begin
            // Data held one cycle past the rising strobe
            pins_next.chip_sel_n = 1'b1;
            dq_oe_next = 1'b0;
            if (step_reg == last_step_reg) begin
               state_next = ST_IDLE;
            end else begin
               step_next = step_reg + 1'b1;
               state_next = ST_WSETUP;
            end
         end
         ST_CLEAR: begin
            pins_next.chip_sel_n = 1'b1;
            pins_next.wr_strobe_n = 1'b1;
            dq_oe_next = 1'b0;
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(CLEAR_CYCLES)) begin
               pins_next.clear_n = 1'b1;
               cnt_next = '0;
               state_next = ST_RELEASE;
               // Software sees this and must reissue a cut program or erase
               aborted_next = !ready_sync_reg[1];
            end
         end
         ST_RELEASE: begin
            // Count saturates so a late ready flag cannot wrap the wait
            if (cnt_reg != CNT_W'(RELEASE_CYCLES))
               cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(RELEASE_CYCLES) && ready_sync_reg[1])
               state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         state_reg <= ST_IDLE;
         pins_reg <= '{addr: 18'h0, chip_sel_n: 1'b1, out_gate_n: 1'b1, wr_strobe_n: 1'b1,
                       clear_n: 1'b1, word_mode: 1'b1, clear_hv: 1'b0, a9_hv: 1'b0};
         cnt_reg <= '0;
         op_reg <= OP_READ;
         step_reg <= 2'd0;
         last_step_reg <= 2'd0;
         rdata_reg <= 16'h0;
         dq_out_reg <= 16'h0;
         dq_oe_reg <= 1'b0;
         aborted_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pins_reg <= pins_next;
         cnt_reg <= cnt_next;
         op_reg <= op_next;
         step_reg <= step_next;
         last_step_reg <= last_step_next;
         rdata_reg <= rdata_next;
         dq_out_reg <= dq_out_next;
         dq_oe_reg <= dq_oe_next;
         aborted_reg <= aborted_next;
      end
   end

   // Software registers; settings are frozen while a sequence runs
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         addr_reg <= 19'h0;
         wdata_reg <= 16'h0;
         word_reg <= 1'b1;
         bypass_reg <= 1'b0;
         hv_clr_reg <= 1'b0;
         hv_a9_reg <= 1'b0;
         rdata_bus_reg <= 32'h0;
      end else begin
         if (WR_I && !busy && ADDR_I == REG_ADDR)
            addr_reg <= WDATA_I[18:0];
         if (WR_I && !busy && ADDR_I == REG_WDATA)
            wdata_reg <= WDATA_I[15:0];
         if (wr_ctrl && !busy) begin
            word_reg <= WDATA_I[CTRL_WORD];
            bypass_reg <= WDATA_I[CTRL_BYPASS];
            hv_clr_reg <= WDATA_I[CTRL_HV_CLR];
            hv_a9_reg <= WDATA_I[CTRL_HV_A9];
         end
         rdata_bus_reg <= RD_I ? rd_mux : 32'h0;
      end
   end

   // Pin inputs pass two flops before use
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         ready_sync_reg <= 2'b00;
         dq_meta_reg <= 16'h0;
         dq_sync_reg <= 16'h0;
      end else begin
         ready_sync_reg <= {ready_sync_reg[0], FL_OP_DONE_FLAG_I};
         dq_meta_reg <= FL_DQ_I;
         dq_sync_reg <= dq_meta_reg;
      end
   end

   assign RDATA_O = rdata_bus_reg;
   assign FL_ADDR_O = pins_reg.addr;
   assign FL_CHIP_SEL_N_O = pins_reg.chip_sel_n;
   assign FL_OUT_GATE_N_O = pins_reg.out_gate_n;
   assign FL_WR_STROBE_N_O = pins_reg.wr_strobe_n;
   assign FL_CLEAR_N_O = pins_reg.clear_n;
   assign FL_WORD_MODE_O = pins_reg.word_mode;
   assign FL_CLEAR_HV_O = pins_reg.clear_hv;
   assign FL_A9_HV_O = pins_reg.a9_hv;
   assign FL_DQ_O = dq_out_reg;
   assign FL_DQ_OE_O = dq_oe_reg;
endmodule

// File: pfh_pkg.sv
// Package for the parallel flash host controller: register map, pin bundle, timing constants
package pfh_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_NS = 40;
   // Bus timing in ns
   localparam int ADDRESS_ACCESS_TIME_NS = 90;
   localparam int SELECT_ACCESS_TIME_NS = 90;
   localparam int CLEAR_PULSE_MIN_TIME_NS = 500;
   localparam int CLEAR_RELEASE_TO_READ_TIME_NS = 50;
   localparam int WRITE_PULSE_NS = 35;
   // Least times round up to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int READ_CYC = ns_to_cyc(ADDRESS_ACCESS_TIME_NS);
   localparam int WRITE_CYC = ns_to_cyc(WRITE_PULSE_NS);
   localparam int CLEAR_CYC = ns_to_cyc(CLEAR_PULSE_MIN_TIME_NS);
   localparam int RELEASE_CYC = ns_to_cyc(CLEAR_RELEASE_TO_READ_TIME_NS);
   localparam int CNT_W = 8;
   // Register offsets (word addresses on the command port)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_RDATA = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   // Control register fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LSB = 1;
   localparam int CTRL_WORD = 4;
   localparam int CTRL_BYPASS = 5;
   localparam int CTRL_HV_CLR = 6;
   localparam int CTRL_HV_A9 = 7;
   // Command codes in the control register
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_PROGRAM = 3'h2;
   localparam logic [2:0] OP_RESET = 3'h3;
   localparam logic [2:0] OP_PROTECT = 3'h4;
   // Command cycle addresses and data for a program sequence
   localparam logic [17:0] UNLOCK_ADDR1 = 18'h00555;
   localparam logic [17:0] UNLOCK_ADDR2 = 18'h002aa;
   localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
   localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
   localparam logic [15:0] PROG_SETUP_DATA = 16'h00a0;
   // Protect cycles need A6=0 A1=1 A0=0; the host forces these pins in word mode only, byte mode drives A0=1
   localparam logic [18:0] PROT_ADDR_MASK = 19'h00043;
   localparam logic [18:0] PROT_ADDR_VAL = 19'h00002;
   // Pins toward the flash, all active-low controls as named
   typedef struct packed {
      logic [17:0] addr;
      logic chip_sel_n;
      logic out_gate_n;
      logic wr_strobe_n;
      logic clear_n;
      logic word_mode;
      logic clear_hv;
      logic a9_hv;
   } pfh_pins_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_WSETUP = 3'b010,
      ST_WPULSE = 3'b011,
      ST_WHOLD = 3'b100,
      ST_CLEAR = 3'b101,
      ST_RELEASE = 3'b110
   } pfh_state_t;
endpackage

// File: pfh_host_asserts.sv
// Checker for the flash host pin sequencing
module pfh_host_asserts
   import pfh_pkg::*;
#(
   parameter int READ_CYCLES = 3,
   parameter int WRITE_CYCLES = 1,
   parameter int CLEAR_CYCLES = 13
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic [17:0] FL_ADDR_O,
   input wire logic FL_CHIP_SEL_N_O,
   input wire logic FL_OUT_GATE_N_O,
   input wire logic FL_WR_STROBE_N_O,
   input wire logic FL_CLEAR_N_O,
   input wire logic FL_A9_HV_O,
   input wire logic [15:0] FL_DQ_O,
   input wire logic FL_DQ_OE_O
);
   logic [7:0] we_cnt, oe_cnt, cl_cnt;
   // Length of the current low phase of the strobe, gate and clear lines
   always_ff @(posedge CLK_I) begin
      we_cnt <= FL_WR_STROBE_N_O ? 8'h00 : we_cnt + 8'h01;
      oe_cnt <= FL_OUT_GATE_N_O ? 8'h00 : oe_cnt + 8'h01;
      cl_cnt <= FL_CLEAR_N_O ? 8'h00 : cl_cnt + 8'h01;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   AST_WR_QUAL: assert property (!FL_WR_STROBE_N_O |-> !FL_CHIP_SEL_N_O && FL_OUT_GATE_N_O)
      else $error("strobe low without select or with gate low");
   AST_RD_QUAL: assert property (!FL_OUT_GATE_N_O && !FL_A9_HV_O |-> FL_WR_STROBE_N_O && !FL_DQ_OE_O)
      else $error("gate low during strobe or host drive");
   AST_WE_SETUP: assert property ($fell(FL_WR_STROBE_N_O) |-> $past(!FL_CHIP_SEL_N_O) && FL_DQ_OE_O)
      else $error("strobe fell without select setup");
   AST_WE_WIDTH: assert property ($rose(FL_WR_STROBE_N_O) |-> we_cnt == 8'(WRITE_CYCLES))
      else $error("strobe pulse width wrong");
   AST_WE_HOLD: assert property (!FL_WR_STROBE_N_O && $past(!FL_WR_STROBE_N_O)
      |-> $stable(FL_ADDR_O) && $stable(FL_DQ_O))
      else $error("address or data moved under strobe");
   AST_READ_TIME: assert property ($rose(FL_OUT_GATE_N_O) |-> oe_cnt >= 8'(READ_CYCLES + 1))
      else $error("gate released before access time");
   AST_READ_ADDR: assert property (!FL_OUT_GATE_N_O && $past(!FL_OUT_GATE_N_O) |-> $stable(FL_ADDR_O))
      else $error("address moved during read");
   AST_CLEAR_WIDTH: assert property ($rose(FL_CLEAR_N_O) |-> cl_cnt == 8'(CLEAR_CYCLES + 1))
      else $error("clear pulse width wrong");
   AST_CLEAR_QUIET: assert property (!FL_CLEAR_N_O |-> FL_CHIP_SEL_N_O && FL_WR_STROBE_N_O)
      else $error("access during clear pulse");
   AST_RELEASE: assert property ($rose(FL_CLEAR_N_O) |-> FL_CHIP_SEL_N_O [*2])
      else $error("access too soon after clear");
   AST_RESET_OUT: assert property ($fell(SRST_I) |-> FL_CHIP_SEL_N_O && FL_CLEAR_N_O && !FL_DQ_OE_O)
      else $error("pins not idle after reset");
   COV_WRITE: cover property ($rose(FL_WR_STROBE_N_O));
   COV_READ: cover property ($rose(FL_OUT_GATE_N_O));
   COV_CLEAR: cover property ($rose(FL_CLEAR_N_O));
endmodule
bind pfh_host pfh_host_asserts #(.READ_CYCLES(READ_CYCLES), .WRITE_CYCLES(WRITE_CYCLES),
   .CLEAR_CYCLES(CLEAR_CYCLES)) u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .FL_ADDR_O(FL_ADDR_O),
   .FL_CHIP_SEL_N_O(FL_CHIP_SEL_N_O), .FL_OUT_GATE_N_O(FL_OUT_GATE_N_O),
   .FL_WR_STROBE_N_O(FL_WR_STROBE_N_O), .FL_CLEAR_N_O(FL_CLEAR_N_O), .FL_A9_HV_O(FL_A9_HV_O),
   .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O));

// File: pfh_flash_model.sv
// Behavioural model of the parallel flash on the far side of the host
module pfh_flash_model
   import pfh_pkg::*;
(
   input wire logic [17:0] addr_i,
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic clear_n_i,
   input wire logic word_i,
   input wire logic clear_hv_i,
   input wire logic bypass_i,
   input wire logic host_oe_i,
   input wire logic [15:0] host_dq_i,
   output logic [15:0] dq_o,
   output logic ready_o,
   output logic prot_o
);
   logic [15:0] mem [64];
   logic [17:0] la;
   logic [1:0] seq;
   logic tog;
   wire drv = clear_n_i && !cs_n_i && !oe_n_i && we_n_i;
   wire [15:0] w = mem[addr_i[5:0]];
   wire [15:0] pat = {8{1'b1, tog}};
   // Undriven lines wiggle so a stale value is never mistaken for data
   assign dq_o = !drv ? pat : word_i ? w : {pat[15:8], (host_oe_i && host_dq_i[15]) ? w[15:8] : w[7:0]};
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 16'h1000 + 16'(i);
      ready_o = 1'b1;
      seq = 2'd0;
      prot_o = 1'b0;
      tog = 1'b0;
      forever #40 tog = ~tog;
   end
   always @(negedge we_n_i, negedge cs_n_i) if (!we_n_i && !cs_n_i) la = addr_i;
   always @(posedge we_n_i) begin
      if (!cs_n_i && oe_n_i && clear_n_i) begin
         if (clear_hv_i) prot_o = prot_o | (!la[6] && la[1:0] == 2'b10);
         else case (seq)
            2'd0: seq = (la == UNLOCK_ADDR1 && host_dq_i == UNLOCK_DATA1) ? 2'd1
               : (bypass_i && host_dq_i == PROG_SETUP_DATA) ? 2'd3 : 2'd0;
            2'd1: seq = (la == UNLOCK_ADDR2 && host_dq_i == UNLOCK_DATA2) ? 2'd2 : 2'd0;
            2'd2: seq = (la == UNLOCK_ADDR1 && host_dq_i == PROG_SETUP_DATA) ? 2'd3 : 2'd0;
            default: begin
               if (!(prot_o && la[5])) mem[la[5:0]] = host_dq_i;
               seq = 2'd0;
               ready_o = 1'b0;
               ready_o <= #400 1'b1;
            end
         endcase
      end
   end
   always @(negedge clear_n_i) seq = 2'd0;
   always @(posedge clear_n_i) ready_o <= #80 1'b1;
endmodule

// File: tb_top.sv
// Testbench for the flash host: register-level sequences against the flash model
module tb_top import pfh_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK_I = 0, SRST_I = 1, WR_I = 0, RD_I = 0, byp = 0;
   logic [3:0] ADDR_I = 0;
   logic [31:0] WDATA_I = 0, d;
   wire [31:0] RDATA_O;
   wire [17:0] fa;
   wire cs_n, oe_n, we_n, cl_n, wm, chv, ahv, doe, rdy, prot;
   wire [15:0] hdq, mdq;
   int error_cnt = 0, n_compared = 0;
   wire [15:0] dq = doe ? hdq : mdq;
   pfh_host uut (.CLK_I(CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
      .RD_I(RD_I), .RDATA_O(RDATA_O), .FL_ADDR_O(fa), .FL_CHIP_SEL_N_O(cs_n), .FL_OUT_GATE_N_O(oe_n),
      .FL_WR_STROBE_N_O(we_n), .FL_CLEAR_N_O(cl_n), .FL_WORD_MODE_O(wm), .FL_CLEAR_HV_O(chv),
      .FL_A9_HV_O(ahv), .FL_DQ_I(dq), .FL_DQ_O(hdq), .FL_DQ_OE_O(doe), .FL_OP_DONE_FLAG_I(rdy));
   pfh_flash_model u_fl (.addr_i(fa), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n), .clear_n_i(cl_n),
      .word_i(wm), .clear_hv_i(chv), .bypass_i(byp), .host_oe_i(doe), .host_dq_i(hdq), .dq_o(mdq),
      .ready_o(rdy), .prot_o(prot));
   initial forever #20 CLK_I = ~CLK_I;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge CLK_I);
      WR_I <= 1;
      ADDR_I <= a;
      WDATA_I <= v;
      @(posedge CLK_I);
      WR_I <= 0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge CLK_I);
      RD_I <= 1;
      ADDR_I <= a;
      @(posedge CLK_I);
      RD_I <= 0;
      @(negedge CLK_I);
      v = RDATA_O;
   endtask
   function automatic logic [31:0] ctl(input logic [2:0] op, input logic w, b, h);
      return {25'h0, h, b, w, op, 1'b1};
   endfunction
   // Go, then poll until idle and the flash reports ready
   task run(input logic [31:0] c);
      logic [31:0] s;
      wr(REG_CTRL, c);
      for (int j = 0; j < 100; j++) begin
         rd(REG_STATUS, s);
         if (s[1:0] == 2'b10) break;
      end
   endtask
   task rda(input logic [31:0] a, input logic w, output logic [31:0] v);
      wr(REG_ADDR, a);
      run(ctl(OP_READ, w, 0, 0));
      rd(REG_RDATA, v);
   endtask
   task prog(input logic [31:0] a, input logic [31:0] v, input logic b);
      wr(REG_ADDR, a);
      wr(REG_WDATA, v);
      run(ctl(OP_PROGRAM, 1, b, 0));
   endtask
   initial begin
      repeat (12) @(posedge CLK_I);
      SRST_I <= 0;
      // Ready flag needs two synchroniser stages before status shows it
      repeat (2) @(posedge CLK_I);
      rd(REG_STATUS, d); chk(d[4:0], 5'h02);
      rd(4'h9, d); chk(d, 0);
      rda(32'h0a, 1, d); chk(d[15:0], 16'h100a);
      rda(32'h0b, 1, d); chk(d[15:0], 16'h100b);
      prog(32'h05, 32'hbeef, 0);
      rda(32'h05, 1, d); chk(d[15:0], 16'hbeef);
      byp <= 1;
      prog(32'h06, 32'h5a5a, 1);
      rda(32'h06, 1, d); chk(d[15:0], 16'h5a5a);
      byp <= 0;
      rda(32'h0e, 0, d); chk(d[7:0], 8'h07);
      run(ctl(OP_RESET, 1, 0, 0));
      rd(REG_STATUS, d); chk(d[1], 1'b1);
      rda(32'h0a, 1, d); chk(d[15:0], 16'h100a);
      wr(REG_ADDR, 32'h20);
      run(ctl(OP_PROTECT, 1, 0, 1));
      rd(REG_STATUS, d); chk(d[2], 1'b1);
      chk(prot, 1'b1);
      prog(32'h30, 32'h1234, 0);
      rda(32'h30, 1, d); chk(d[15:0], 16'h1030);
      final_report;
   end
   initial begin
      #200us;
      error_cnt++;
      final_report;
   end
endmodule
